/* File: design/csl_lock_det.sv */
`timescale 1ns/1ps
`default_nettype none
module csl_lock_det
    import csl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        ref_tick_in,
    input  wire logic        fb_tick_in,
    input  wire logic [15:0] expect_in,
    output logic             locked_out,
    output logic             lock_change_out
);

    function automatic logic [16:0] csl_absdiff(input logic [16:0] a, input logic [16:0] b);
        csl_absdiff = (a > b) ? (a - b) : (b - a);
    endfunction

    csl_ld_state_t s_r;
    csl_ld_state_t s_nxt;
    logic [16:0]   fb_total;
    logic          window_end;
    logic          in_tol;

    always_comb
    begin
        s_nxt      = s_r;
        fb_total   = {1'b0, s_r.fb_cnt} + {16'h0000, fb_tick_in};
        window_end = ref_tick_in && (s_r.ref_cnt == LD_LAST_REF);
        in_tol     = csl_absdiff(fb_total, {1'b0, expect_in}) <= LD_TOL;
        if (ref_tick_in)
        begin
            s_nxt.ref_cnt = s_r.ref_cnt + 7'h01;
        end
        if (window_end)
        begin
            // Judge once per 128 reference cycles
            s_nxt.locked = in_tol;
            s_nxt.fb_cnt = 16'h0000;
        end
        else if (fb_tick_in && s_r.fb_cnt != 16'hFFFF)
        begin
            s_nxt.fb_cnt = s_r.fb_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign locked_out      = s_r.locked;
    assign lock_change_out = s_r.locked != s_nxt.locked;

    lock_judge_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        window_end |=> (locked_out == $past(in_tol)))
        else $error("Lock state not judged at window end");

endmodule
`default_nettype wire

/* File: design/csl_top.sv */
// Functional notes
// - Out of reset the system clock runs from the internal RC oscillator.
// - Software switch to crystal only after qualification; qualified flag readable.
// - Edge monitor flags missing edges over 2.2 us, within 5 us; reset or self-clock.
// - Self-clock mode keeps the system running from a slow fallback clock.
// - Entry to or exit from self-clock mode sets a flag; interrupt when enabled.
// - Lock detector checks feedback count each 128 reference cycles; unlock beyond 2.
// - Any lock state change sets a flag; interrupt when enabled.
// - On loss of lock the bus clock is the PLL clock divided by four.
// - System clock from crystal or PLL; PLL reference from RC or crystal.
// - Three time bases: crystal, RC, periodic timer; core uses selected clock.
// - If the RC oscillator never starts the device stays in reset.
// - With crystal as system clock the RC feeds only tick timer or watchdog.
// - Watchdog may be clocked from the periodic timer time base.
// - Readable lock status bit once the PLL has locked.
// - Fetch from an invalid address causes an illegal address reset.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module csl_top
    import csl_pkg::*;
#(
    parameter logic [7:0]  OSC_QUAL_EDGES = 8'h40,
    parameter logic [15:0] LEGAL_LO       = 16'h4000,
    parameter logic [15:0] LEGAL_HI       = 16'hFFFF
)
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Clock sources
    input  wire logic        crystal_oscillator_in,
    input  wire logic        irc_ok_in,
    input  wire logic        pll_ref_tick_in,
    input  wire logic        pll_fb_tick_in,
    input  wire logic        fetch_valid_in,
    input  wire logic [15:0] fetch_addr_in,
    // Clock steering
    output logic [1:0]       sysclk_src_out,
    output logic             pll_ref_osc_out,
    output logic             bus_div4_out,
    output logic             irc_to_pll_en_out,
    output logic             rti_src_osc_out,
    output logic             wdog_src_api_out,
    output logic             self_clock_mode_out,
    output logic             sys_reset_out,
    output logic             irq_out
);

    function automatic logic csl_mapped(input logic [11:0] a);
        csl_mapped = (a == CSL_CTRL_OFF) || (a == CSL_STATUS_OFF) || (a == CSL_FLAGS_OFF) ||
                     (a == CSL_MASK_OFF) || (a == CSL_EXPECT_OFF);
    endfunction

    csl_state_t s_r;
    csl_state_t s_nxt;

    logic       pll_locked;
    logic       lock_change;
    logic       osc_edge;
    logic       cmu_fail;
    logic       wr_en;
    logic       rd_setup;
    logic       illegal_fetch;
    logic       want_osc;
    logic [1:0] req_src;
    logic [2:0] flag_set;
    logic [31:0] status_word;

    csl_lock_det u_lock_det (
        .clk_in          (clk_in),
        .resetn_in       (resetn_in),
        .ref_tick_in     (pll_ref_tick_in),
        .fb_tick_in      (pll_fb_tick_in),
        .expect_in       (s_r.expect_cnt),
        .locked_out      (pll_locked),
        .lock_change_out (lock_change)
    );

    always_comb
    begin
        s_nxt         = s_r;
        wr_en         = psel && penable && pwrite && csl_mapped(paddr);
        rd_setup      = psel && !penable && !pwrite;
        osc_edge      = crystal_oscillator_in ^ s_r.osc_prev;
        // Qualified crystal missing edges past the minimum gap
        cmu_fail      = s_r.osc_ok && !osc_edge && (s_r.gap_cnt == CMU_FAIL_CYC - 8'h01);
        illegal_fetch = fetch_valid_in && ((fetch_addr_in < LEGAL_LO) || (fetch_addr_in > LEGAL_HI));
        req_src       = s_r.ctrl[CTRL_SRC_LSB +: 2];
        want_osc      = (req_src == CSL_SRC_OSC) ||
                        (req_src == CSL_SRC_PLL && s_r.ctrl[CTRL_PLLREF_BIT]);
        flag_set      = 3'h0;
        status_word   = 32'h0000_0000;
        status_word[STAT_QUAL_BIT]         = s_r.osc_ok;
        status_word[STAT_SCM_BIT]          = s_r.self_clock_mode;
        status_word[STAT_LOCK_BIT]         = pll_locked;
        status_word[STAT_SRC_LSB +: 2]     = s_r.src;
        status_word[STAT_DIV4_BIT]         = s_r.div4;

        // Crystal edge monitor and qualification
        s_nxt.osc_prev = crystal_oscillator_in;
        if (osc_edge)
        begin
            s_nxt.gap_cnt = 8'h00;
        end
        else if (s_r.gap_cnt != CMU_MAX_CYC)
        begin
            s_nxt.gap_cnt = s_r.gap_cnt + 8'h01;
        end
        if (!s_r.osc_ok)
        begin
            // A gap during qualification restarts the count
            if (!osc_edge && s_r.gap_cnt == CMU_FAIL_CYC - 8'h01)
            begin
                s_nxt.qual_cnt = 8'h00;
            end
            else if (osc_edge)
            begin
                if (s_r.qual_cnt == OSC_QUAL_EDGES - 8'h01)
                begin
                    s_nxt.osc_ok   = 1'b1;
                    s_nxt.qual_cnt = 8'h00;
                end
                else
                begin
                    s_nxt.qual_cnt = s_r.qual_cnt + 8'h01;
                end
            end
        end
        else if (cmu_fail)
        begin
            s_nxt.osc_ok = 1'b0;
        end

        // Self-clock mode entry and exit
        if (cmu_fail && s_r.ctrl[CTRL_SCMEN_BIT])
        begin
            s_nxt.self_clock_mode = 1'b1;
            s_nxt.src = CSL_SRC_SCM;
        end
        else if (s_r.self_clock_mode && s_nxt.osc_ok)
        begin
            // Leave to the RC clock; the next cycle re-applies the source requested in CTRL
            s_nxt.self_clock_mode = 1'b0;
            s_nxt.src = CSL_SRC_IRC;
        end
        else if (!s_r.self_clock_mode)
        begin
            // Source selection, only from qualified sources
            unique case (req_src)
                CSL_SRC_IRC:
                begin
                    s_nxt.src = CSL_SRC_IRC;
                end
                CSL_SRC_OSC:
                begin
                    if (s_r.osc_ok)
                    begin
                        s_nxt.src = CSL_SRC_OSC;
                    end
                end
                CSL_SRC_PLL:
                begin
                    if (!s_r.ctrl[CTRL_PLLREF_BIT] || s_r.osc_ok)
                    begin
                        s_nxt.src = CSL_SRC_PLL;
                    end
                end
                default:
                begin
                    s_nxt.src = s_r.src;
                end
            endcase
            // Crystal lost without self-clock: fall back so no stale source stays
            if (want_osc && !s_nxt.osc_ok)
            begin
                s_nxt.src = CSL_SRC_IRC;
            end
        end
        if (s_nxt.self_clock_mode != s_r.self_clock_mode)
        begin
            flag_set[FLG_SCM_BIT] = 1'b1;
        end
        if (lock_change)
        begin
            flag_set[FLG_LOCK_BIT] = 1'b1;
        end
        if (illegal_fetch)
        begin
            flag_set[FLG_ILL_BIT] = 1'b1;
        end

        // Unlocked PLL keeps the bus clock well below its maximum
        s_nxt.div4 = (s_nxt.src == CSL_SRC_PLL) && !pll_locked;

        // Reset requests: stretched pulse for monitor and illegal address
        if (illegal_fetch || (cmu_fail && !s_r.ctrl[CTRL_SCMEN_BIT]))
        begin
            s_nxt.rst_cnt = RST_PULSE_CYC;
        end
        else if (s_r.rst_cnt != 5'h00)
        begin
            s_nxt.rst_cnt = s_r.rst_cnt - 5'h01;
        end
        s_nxt.sys_rst = !irc_ok_in || (s_nxt.rst_cnt != 5'h00);

        // Register writes; hardware set wins over a write-one clear
        s_nxt.flags = s_r.flags | flag_set;
        if (wr_en)
        begin
            unique case (paddr)
                CSL_CTRL_OFF:
                begin
                    s_nxt.ctrl = pwdata[5:0];
                end
                CSL_FLAGS_OFF:
                begin
                    s_nxt.flags = (s_r.flags & ~pwdata[2:0]) | flag_set;
                end
                CSL_MASK_OFF:
                begin
                    s_nxt.mask = pwdata[2:0];
                end
                CSL_EXPECT_OFF:
                begin
                    s_nxt.expect_cnt = pwdata[15:0];
                end
                default:
                begin
                    s_nxt.ctrl = s_r.ctrl;
                end
            endcase
        end

        // Read data captured in setup phase, presented in access phase
        if (rd_setup)
        begin
            unique case (paddr)
                CSL_CTRL_OFF:   s_nxt.prdata = {26'h0000000, s_r.ctrl};
                CSL_STATUS_OFF: s_nxt.prdata = status_word;
                CSL_FLAGS_OFF:  s_nxt.prdata = {29'h00000000, s_r.flags};
                CSL_MASK_OFF:   s_nxt.prdata = {29'h00000000, s_r.mask};
                CSL_EXPECT_OFF: s_nxt.prdata = {16'h0000, s_r.expect_cnt};
                default:        s_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            s_r            <= '0;
            s_r.src        <= CSL_SRC_IRC;
            s_r.ctrl       <= CTRL_RST;
            s_r.flags      <= FLAGS_RST;
            s_r.mask       <= MASK_RST;
            s_r.expect_cnt <= EXPECT_RST;
            s_r.sys_rst    <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata              = s_r.prdata;
    assign pready              = 1'b1;
    assign pslverr             = psel && penable && !csl_mapped(paddr);
    assign sysclk_src_out      = s_r.src;
    assign pll_ref_osc_out     = s_r.ctrl[CTRL_PLLREF_BIT];
    assign bus_div4_out        = s_r.div4;
    // RC feeds the PLL only when it is the PLL reference in use
    assign irc_to_pll_en_out   = (s_r.src == CSL_SRC_PLL) && !s_r.ctrl[CTRL_PLLREF_BIT];
    assign rti_src_osc_out     = s_r.ctrl[CTRL_RTIOSC_BIT] && s_r.osc_ok;
    assign wdog_src_api_out    = s_r.ctrl[CTRL_WDAPI_BIT];
    assign self_clock_mode_out = s_r.self_clock_mode;
    assign sys_reset_out       = s_r.sys_rst;
    assign irq_out             = |(s_r.flags & s_r.mask);

    osc_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_r.src == CSL_SRC_OSC) |-> $past(s_r.osc_ok))
        else $error("Crystal selected before qualification");

    gap_detect_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_r.osc_ok && s_r.gap_cnt == CMU_FAIL_CYC - 8'h01 && !osc_edge) |=> !s_r.osc_ok)
        else $error("Missing crystal edges not detected");

    scm_entry_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (cmu_fail && s_r.ctrl[CTRL_SCMEN_BIT]) |=> (self_clock_mode_out && sysclk_src_out == CSL_SRC_SCM))
        else $error("Self-clock mode not entered on crystal loss");

    scm_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $changed(s_r.self_clock_mode) |-> s_r.flags[FLG_SCM_BIT])
        else $error("Self-clock change not flagged");

    lock_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $changed(pll_locked) |-> (s_r.flags[FLG_LOCK_BIT] && (irq_out || !s_r.mask[FLG_LOCK_BIT])))
        else $error("Lock change not flagged");

    div_four_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !pll_locked |=> (bus_div4_out == (s_r.src == CSL_SRC_PLL)))
        else $error("Bus clock not divided while unlocked");

    irc_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !irc_ok_in |=> sys_reset_out)
        else $error("Reset released without RC oscillator");

    osc_only_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sysclk_src_out == CSL_SRC_OSC) |-> !irc_to_pll_en_out)
        else $error("RC steered to PLL while on crystal");

    illegal_address_reset_rst_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        illegal_fetch |=> sys_reset_out[*8])
        else $error("Illegal address reset too short");

    flag_keep_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_r.flags[FLG_SCM_BIT] && !(wr_en && paddr == CSL_FLAGS_OFF && pwdata[FLG_SCM_BIT]))
        |=> s_r.flags[FLG_SCM_BIT])
        else $error("Change flag lost without software clear");

endmodule
`default_nettype wire

/* File: inc/csl_pkg.sv */
`default_nettype none
package csl_pkg;

    // APB register map, byte addresses
    localparam logic [11:0] CSL_CTRL_OFF   = 12'h000;
    localparam logic [11:0] CSL_STATUS_OFF = 12'h004;
    localparam logic [11:0] CSL_FLAGS_OFF  = 12'h008;
    localparam logic [11:0] CSL_MASK_OFF   = 12'h00C;
    localparam logic [11:0] CSL_EXPECT_OFF = 12'h010;

    // CTRL fields
    localparam int CTRL_SRC_LSB     = 0;
    localparam int CTRL_PLLREF_BIT  = 2;
    localparam int CTRL_SCMEN_BIT   = 3;
    localparam int CTRL_WDAPI_BIT   = 4;
    localparam int CTRL_RTIOSC_BIT  = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // STATUS fields
    localparam int STAT_QUAL_BIT   = 0;
    localparam int STAT_SCM_BIT    = 1;
    localparam int STAT_LOCK_BIT   = 2;
    localparam int STAT_SRC_LSB    = 3;
    localparam int STAT_DIV4_BIT   = 5;

    // FLAGS / MASK fields
    localparam int FLG_SCM_BIT  = 0;
    localparam int FLG_LOCK_BIT = 1;
    localparam int FLG_ILL_BIT  = 2;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [2:0] MASK_RST  = 3'h0;
    localparam logic [15:0] EXPECT_RST = 16'h0000;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int CMU_MIN_NS    = 2200;
    localparam int CMU_MAX_NS    = 5000;
    localparam logic [7:0] CMU_MIN_CYC  = 8'((CMU_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CMU_MAX_CYC  = 8'(CMU_MAX_NS / CLK_PERIOD_NS);
    localparam logic [7:0] CMU_FAIL_CYC = CMU_MIN_CYC + 8'h01;
    localparam logic [4:0] RST_PULSE_CYC = 5'h10;

    // Lock detector
    localparam logic [6:0]  LD_LAST_REF = 7'h7F;
    localparam logic [16:0] LD_TOL      = 17'h00002;

    typedef enum logic [1:0] {
        CSL_SRC_IRC = 2'b00,
        CSL_SRC_OSC = 2'b01,
        CSL_SRC_PLL = 2'b10,
        CSL_SRC_SCM = 2'b11
    } csl_src_t;

    typedef struct packed {
        logic [6:0]  ref_cnt;
        logic [15:0] fb_cnt;
        logic        locked;
    } csl_ld_state_t;

    typedef struct packed {
        logic        osc_prev;
        logic [7:0]  gap_cnt;
        logic [7:0]  qual_cnt;
        logic        osc_ok;
        logic        self_clock_mode;
        csl_src_t    src;
        logic [5:0]  ctrl;
        logic [2:0]  flags;
        logic [2:0]  mask;
        logic [15:0] expect_cnt;
        logic [31:0] prdata;
        logic [4:0]  rst_cnt;
        logic        sys_rst;
        logic        div4;
    } csl_state_t;

endpackage
`default_nettype wire

/* File: tb/csl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module csl_tb_top
    import csl_pkg::*;
;
    logic        clk_in;
    logic        resetn_in;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        xtal;
    logic        run;
    logic        slow;
    logic        irc_ok;
    logic        ref_t;
    logic        fb_t;
    logic        fvalid;
    logic [15:0] faddr;
    logic [1:0]  src;
    logic        ref_osc;
    logic        div4;
    logic        irc_pll;
    logic        rti_osc;
    logic        wd_api;
    logic        self_clock_mode;
    logic        srst;
    logic        irq;
    logic [31:0] seed;
    int          n_errors;
    int          compares;
    int          cyc;
    int          e;
    int          n;
    int          m;

    csl_xtal_model XTAL (.run_in(run), .slow_in(slow), .xtal_out(xtal));

    csl_top #(.OSC_QUAL_EDGES(8'h04)) DUT (
        .clk_in(clk_in), .resetn_in(resetn_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crystal_oscillator_in(xtal),
        .irc_ok_in(irc_ok), .pll_ref_tick_in(ref_t), .pll_fb_tick_in(fb_t),
        .fetch_valid_in(fvalid), .fetch_addr_in(faddr), .sysclk_src_out(src),
        .pll_ref_osc_out(ref_osc), .bus_div4_out(div4), .irc_to_pll_en_out(irc_pll),
        .rti_src_osc_out(rti_osc), .wdog_src_api_out(wd_api),
        .self_clock_mode_out(self_clock_mode), .sys_reset_out(srst), .irq_out(irq));

    always #10 clk_in = ~clk_in;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic lock_ok(input int cnt, input int ex);
        return (cnt - ex <= 2) && (ex - cnt <= 2);
    endfunction

    task automatic test_done;
        $display("counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic er);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for pready
        do
        begin
            @(posedge clk_in);
        end
        while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        er;
        apb(1'b1, a, d, q, er);
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] msk,
                      input logic [31:0] ex);
        logic [31:0] q;
        logic        er;
        apb(1'b0, a, 32'h00000000, q, er);
        chk(nm, ex, q & msk);
        chk("pslverr", 32'(a > CSL_EXPECT_OFF), 32'(er));
    endtask

    // Reference tick every fourth cycle, so 128 ticks span 512 cycles
    task automatic lock_win(input int cnt);
        for (int c = 0; c < 512; c++)
        begin
            ref_t <= (c % 4 == 3);
            fb_t  <= (c < cnt);
            @(posedge clk_in);
        end
        ref_t <= 1'b0;
        fb_t  <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask

    task automatic wsig(input logic s, input logic v, output int cnt);
        cnt = 0;
        while ((s ? srst : self_clock_mode) !== v)
        begin
            @(posedge clk_in);
            cnt++;
        end
    endtask

    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            test_done;
        end
    end

    initial
    begin
        clk_in = 1'b0;
        resetn_in = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {run, slow, ref_t, fb_t, fvalid, faddr} = '0;
        irc_ok = 1'b1;
        seed = 32'h00000015;
        n_errors = 0;
        compares = 0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk("src", 0, 32'(src));
        chk("sys_reset", 0, 32'(srst));
        chk("irq", 0, 32'(irq));
        rd("ctrl", CSL_CTRL_OFF, 32'hFFFFFFFF, 32'(CTRL_RST));
        rd("flags", CSL_FLAGS_OFF, 32'hFFFFFFFF, 32'(FLAGS_RST));
        rd("mask", CSL_MASK_OFF, 32'hFFFFFFFF, 32'(MASK_RST));
        rd("unmapped", 12'h014, 32'hFFFFFFFF, 32'h00000000);
        $display("test reset done");

        seed = xs(seed);
        e = 100 + int'(seed % 200);
        wr(CSL_EXPECT_OFF, 32'(e));
        wr(CSL_MASK_OFF, 32'h00000007);
        seed = xs(seed);
        n = e + int'(seed % 5) - 2;
        lock_win(n);
        rd("locked", CSL_STATUS_OFF, 32'h4, 32'(lock_ok(n, e)) << 2);
        rd("lock_flag", CSL_FLAGS_OFF, 32'h7, 32'h2);
        chk("irq_lock", 1, 32'(irq));
        wr(CSL_FLAGS_OFF, 32'h00000002);
        chk("irq_clr", 0, 32'(irq));
        wr(CSL_CTRL_OFF, 32'h00000002);
        repeat (2) @(posedge clk_in);
        chk("src_pll", 2, 32'(src));
        chk("irc_to_pll", 1, 32'(irc_pll));
        chk("div4_locked", 0, 32'(div4));
        seed = xs(seed);
        m = seed[0] ? e + 3 : e - 3;
        lock_win(m);
        chk("div4", 32'(!lock_ok(m, e)), 32'(div4));
        rd("unlock", CSL_STATUS_OFF, 32'h24, 32'h20);
        rd("lock_flag2", CSL_FLAGS_OFF, 32'h7, 32'h2);
        wr(CSL_CTRL_OFF, 32'h00000014);
        repeat (2) @(posedge clk_in);
        chk("ref_osc", 1, 32'(ref_osc));
        chk("wdog_api", 1, 32'(wd_api));
        chk("irc_to_pll_off", 0, 32'(irc_pll));
        wr(CSL_FLAGS_OFF, 32'h00000007);
        $display("test lock done");

        wr(CSL_CTRL_OFF, 32'h00000009);
        repeat (2) @(posedge clk_in);
        chk("src_unqual", 0, 32'(src));
        rd("unqual", CSL_STATUS_OFF, 32'h1, 32'h0);
        run <= 1'b1;
        repeat (40) @(posedge clk_in);
        rd("qual", CSL_STATUS_OFF, 32'h1, 32'h1);
        wr(CSL_CTRL_OFF, 32'h00000029);
        repeat (2) @(posedge clk_in);
        chk("src_osc", 1, 32'(src));
        chk("rti_osc", 1, 32'(rti_osc));
        run <= 1'b0;
        wsig(1'b0, 1'b1, n);
        chk("scm_delay", 1, 32'(n >= 107 && n <= 250));
        repeat (2) @(posedge clk_in);
        chk("src_scm", 3, 32'(src));
        rd("scm_flag", CSL_FLAGS_OFF, 32'h7, 32'h1);
        chk("irq_scm", 1, 32'(irq));
        wr(CSL_FLAGS_OFF, 32'h00000001);
        chk("irq_scm_clr", 0, 32'(irq));
        slow <= 1'b1;
        run <= 1'b1;
        wsig(1'b0, 1'b0, n);
        rd("scm_exit", CSL_FLAGS_OFF, 32'h7, 32'h1);
        repeat (8) @(posedge clk_in);
        chk("src_back", 1, 32'(src));
        wr(CSL_CTRL_OFF, 32'h00000006);
        repeat (2) @(posedge clk_in);
        chk("src_pll_osc", 2, 32'(src));
        chk("irc_to_pll_osc", 0, 32'(irc_pll));
        wr(CSL_FLAGS_OFF, 32'h00000001);
        slow <= 1'b0;
        $display("test self clock done");

        wr(CSL_CTRL_OFF, 32'h00000001);
        run <= 1'b0;
        wsig(1'b1, 1'b1, n);
        chk("rst_delay", 1, 32'(n >= 107 && n <= 250));
        chk("no_scm", 0, 32'(self_clock_mode));
        wsig(1'b1, 1'b0, n);
        chk("rst_len", 32'(RST_PULSE_CYC), 32'(n));
        $display("test crystal loss reset done");

        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            fvalid <= 1'b1;
            faddr <= 16'h4000 + 16'(seed % 32'h0000C000);
            @(posedge clk_in);
        end
        fvalid <= 1'b0;
        rd("legal_fetch", CSL_FLAGS_OFF, 32'h4, 32'h0);
        seed = xs(seed);
        fvalid <= 1'b1;
        faddr <= 16'(seed % 32'h00004000);
        @(posedge clk_in);
        fvalid <= 1'b0;
        wsig(1'b1, 1'b1, n);
        chk("ill_rst", 1, 32'(n <= 2));
        wsig(1'b1, 1'b0, n);
        rd("ill_flag", CSL_FLAGS_OFF, 32'h4, 32'h4);
        chk("irq_ill", 1, 32'(irq));
        wr(CSL_MASK_OFF, 32'h00000000);
        chk("irq_masked", 0, 32'(irq));
        $display("test illegal fetch done");

        irc_ok <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk("irc_dead", 1, 32'(srst));
        irc_ok <= 1'b1;
        $display("test rc dead done");
        test_done;
    end
endmodule
`default_nettype wire

/* File: tb/csl_xtal_model.sv */
`timescale 1ns/1ps
`default_nettype none
module csl_xtal_model #(
    parameter int FAST_NS = 47,
    parameter int SLOW_NS = 97
)
(
    input  wire logic run_in,
    input  wire logic slow_in,
    output logic      xtal_out
);
    // A stopped resonator freezes at its last level
    // Non-blocking toggle: a toggle on a clock edge is seen one edge later, never raced
    initial
    begin
        xtal_out = 1'b0;
        forever
        begin
            #(slow_in ? SLOW_NS : FAST_NS);
            if (run_in)
                xtal_out <= ~xtal_out;
        end
    end
endmodule
`default_nettype wire
